// file: src/pmc_defines.svh
// Constants for the power mode and loop clock controller
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// Loop feedback divider, fixed
`define FB_DIV          5'h0A
// Default tolerance on feedback count per oscillator period
`define FB_TOL          1

// Timing base and oscillator loss window
`define CLK_PERIOD_NS   25
`define OSC_LOSS_NS     500
`define OSC_LOSS_CYC    ((`OSC_LOSS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Output divider select codes
`define KSEL_2          3'h0
`define KSEL_16         3'h1
`define KSEL_4          3'h2
`define KSEL_5          3'h3
`define KSEL_6          3'h4
`define KSEL_8          3'h5
`define KSEL_9          3'h6
`define KSEL_10         3'h7

// Reset values
`define NMI_IDLE_LEVEL  1'b1

`endif

// file: src/pmc_pkg.sv
// Types shared by the power mode and loop clock controller
package pmc_pkg;

  // Power sequencer states, one-hot
  typedef enum logic [9:0] {
    PM_RUN         = 10'h001,
    PM_IDLE        = 10'h002,
    PM_SHUT_PERIPH = 10'h004,
    PM_SHUT_CPU    = 10'h008,
    PM_SLEEP       = 10'h010,
    PM_SHUT_SYS    = 10'h020,
    PM_DEEP        = 10'h040,
    PM_WAKE_SYS    = 10'h080,
    PM_WAKE_CPU    = 10'h100,
    PM_WAKE_PERIPH = 10'h200
  } pm_state_type;

endpackage

// file: src/power_mode_and_pll_clock_control.sv
// Power mode sequencer, output divider and clock fail-safe logic
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defines.svh"

module power_mode_and_pll_clock_control #(
  parameter int NUM_PERIPH = 8,
  parameter int FB_TOL     = `FB_TOL
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // Software requests and configuration
  input  wire logic                    idle_req_i,
  input  wire logic                    sleep_req_i,
  input  wire logic                    deep_sleep_req_i,
  input  wire logic [NUM_PERIPH-1:0]   periph_enable_i,
  input  wire logic [NUM_PERIPH-1:0]   periph_sleep_enable_i,
  input  wire logic [2:0]              output_divide_select_i,
  input  wire logic                    fail_clear_i,
  // Wake sources
  input  wire logic                    irq_enabled_i,
  input  wire logic [NUM_PERIPH-1:0]   periph_irq_i,
  input  wire logic                    wdt_event_i,
  input  wire logic                    nmi_n_i,
  input  wire logic                    ext_wake_i,
  // Oscillator and loop
  input  wire logic                    osc_ref_i,
  input  wire logic                    vco_tick_i,
  input  wire logic                    pll_lock_i,
  // Clock gates and mode
  output logic                         cpu_clk_en_o,
  output logic                         sys_clk_en_o,
  output logic [NUM_PERIPH-1:0]        periph_clk_en_o,
  output pmc_pkg::pm_state_type        power_mode_o,
  // Derived system clock
  output logic                         sys_tick_o,
  output logic                         sys_clk_level_o,
  output logic [4:0]                   div_factor_o,
  // Fail-safe status
  output logic                         osc_loss_o,
  output logic                         osc_deviation_o,
  output logic                         emergency_o
);
  import pmc_pkg::*;

  // ****************************************************
  // Functions
  // ****************************************************

  // Output divider select to factor K
  function automatic logic [4:0] k_decode(input logic [2:0] sel);
    logic [4:0] k;
    k = 5'h02;
    case (sel)
      `KSEL_2:  k = 5'h02;
      `KSEL_16: k = 5'h10;
      `KSEL_4:  k = 5'h04;
      `KSEL_5:  k = 5'h05;
      `KSEL_6:  k = 5'h06;
      `KSEL_8:  k = 5'h08;
      `KSEL_9:  k = 5'h09;
      `KSEL_10: k = 5'h0A;
      default:  k = 5'h02;
    endcase
    return k;
  endfunction

  // Processor clock runs in these states only
  function automatic logic cpu_on(input pm_state_type s);
    return (s == PM_RUN) || (s == PM_SHUT_PERIPH) || (s == PM_WAKE_CPU) || (s == PM_WAKE_PERIPH);
  endfunction

  // System clock is cut only around Deep Sleep
  function automatic logic sys_on(input pm_state_type s);
    return !((s == PM_SHUT_SYS) || (s == PM_DEEP));
  endfunction

  // Full peripheral set allowed in these states
  function automatic logic full_on(input pm_state_type s);
    return (s == PM_RUN) || (s == PM_IDLE) || (s == PM_WAKE_PERIPH);
  endfunction

  // ****************************************************
  // Power mode sequencer
  // ****************************************************

  pm_state_type          state;
  pm_state_type          next_state;
  logic                  deep_target;
  logic                  next_deep_target;
  logic                  nmi_prev;
  logic                  nmi_fall;
  logic                  wake_idle;
  logic                  wake_sleep;
  logic                  next_cpu_clk_en;
  logic                  next_sys_clk_en;
  logic [NUM_PERIPH-1:0] next_periph_clk_en;

  // Wake conditions; reset itself returns to Run asynchronously
  assign nmi_fall   = nmi_prev && !nmi_n_i;
  assign wake_idle  = irq_enabled_i || wdt_event_i || nmi_fall;
  assign wake_sleep = (|(periph_irq_i & periph_clk_en_o)) || wdt_event_i || nmi_fall;

  // Next state and gate values; wake events during shutdown steps wait for the target
  always_comb begin
    next_state       = state;
    next_deep_target = deep_target;
    case (state)
      PM_RUN: begin
        if (deep_sleep_req_i || sleep_req_i) begin
          next_state       = PM_SHUT_PERIPH;
          next_deep_target = deep_sleep_req_i;
        end else if (idle_req_i) begin
          next_state = PM_IDLE;
        end
      end
      PM_IDLE: begin
        if (wake_idle) begin
          next_state = PM_RUN;
        end
      end
      PM_SHUT_PERIPH: next_state = PM_SHUT_CPU;
      PM_SHUT_CPU:    next_state = deep_target ? PM_SHUT_SYS : PM_SLEEP;
      PM_SLEEP: begin
        if (wake_sleep) begin
          next_state = PM_WAKE_CPU;
        end
      end
      PM_SHUT_SYS:    next_state = PM_DEEP;
      PM_DEEP: begin
        if (ext_wake_i) begin
          next_state = PM_WAKE_SYS;
        end
      end
      PM_WAKE_SYS:    next_state = PM_WAKE_CPU;
      PM_WAKE_CPU:    next_state = PM_WAKE_PERIPH;
      PM_WAKE_PERIPH: next_state = PM_RUN;
      default:        next_state = PM_RUN;
    endcase
    next_cpu_clk_en    = cpu_on(next_state);
    next_sys_clk_en    = sys_on(next_state);
    // Sleep keeps only configured units; Deep Sleep cuts all
    next_periph_clk_en = periph_enable_i
                       & (full_on(next_state) ? {NUM_PERIPH{1'b1}} : periph_sleep_enable_i)
                       & {NUM_PERIPH{sys_on(next_state)}};
  end

  // Gates are registered from the next state so they match power_mode_o
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state           <= PM_RUN;
      deep_target     <= 1'b0;
      nmi_prev        <= `NMI_IDLE_LEVEL;
      cpu_clk_en_o    <= 1'b1;
      sys_clk_en_o    <= 1'b1;
      periph_clk_en_o <= '0;
    end else begin
      state           <= next_state;
      deep_target     <= next_deep_target;
      nmi_prev        <= nmi_n_i;
      cpu_clk_en_o    <= next_cpu_clk_en;
      sys_clk_en_o    <= next_sys_clk_en;
      periph_clk_en_o <= next_periph_clk_en;
    end
  end

  assign power_mode_o = state;

  // ****************************************************
  // Output divider
  // ****************************************************

  logic [4:0] div_cnt;
  logic [4:0] next_div_cnt;
  logic [4:0] k_sel;
  logic       osc_prev;
  logic       osc_rise;
  logic       next_sys_tick;
  logic       next_sys_level;

  assign k_sel    = k_decode(output_divide_select_i);
  assign osc_rise = osc_ref_i && !osc_prev;

  // Count loop ticks modulo K; high for floor(K/2) gives 40/44 percent on odd K
  always_comb begin
    next_div_cnt = div_cnt;
    if (vco_tick_i) begin
      next_div_cnt = (div_cnt >= k_sel - 5'h01) ? 5'h00 : div_cnt + 5'h01;
    end else if (div_cnt >= k_sel) begin
      next_div_cnt = 5'h00;
    end
    // Under emergency the oscillator drives the system clock directly
    if (emergency_o) begin
      next_sys_tick  = osc_rise;
      next_sys_level = osc_ref_i;
    end else begin
      next_sys_tick  = vco_tick_i && (div_cnt == k_sel - 5'h01);
      next_sys_level = next_div_cnt < (k_sel >> 1);
    end
    next_sys_tick  = next_sys_tick && next_sys_clk_en;
    next_sys_level = next_sys_level && next_sys_clk_en;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt         <= 5'h00;
      sys_tick_o      <= 1'b0;
      sys_clk_level_o <= 1'b0;
      div_factor_o    <= 5'h02;
    end else begin
      div_cnt         <= next_div_cnt;
      sys_tick_o      <= next_sys_tick;
      sys_clk_level_o <= next_sys_level;
      div_factor_o    <= k_sel;
    end
  end

  // ****************************************************
  // Fail-safe monitor
  // ****************************************************

  localparam logic [7:0] LOSS_CYC = 8'(`OSC_LOSS_CYC);
  localparam logic [4:0] FB_LO    = 5'(`FB_DIV - FB_TOL);
  localparam logic [4:0] FB_HI    = 5'(`FB_DIV + FB_TOL);

  logic [4:0] fb_cnt;
  logic [4:0] next_fb_cnt;
  logic [7:0] gap_cnt;
  logic [7:0] next_gap_cnt;
  logic       edge_seen;
  logic       next_edge_seen;
  logic       lock_prev;
  logic       dev_event;
  logic       loss_event;
  logic       next_osc_loss;
  logic       next_osc_dev;
  logic       next_emergency;

  // Only a full period is judged, so the first edge after reset is skipped
  assign dev_event  = osc_rise && edge_seen && ((fb_cnt < FB_LO) || (fb_cnt > FB_HI));
  assign loss_event = (gap_cnt == LOSS_CYC - 8'h01) && !osc_rise;

  // Set wins over software clear for every fault flag
  always_comb begin
    next_edge_seen = edge_seen || osc_rise;
    if (osc_rise) begin
      next_fb_cnt  = vco_tick_i ? 5'h01 : 5'h00;
      next_gap_cnt = 8'h00;
    end else begin
      next_fb_cnt  = (vco_tick_i && fb_cnt != 5'h1F) ? fb_cnt + 5'h01 : fb_cnt;
      next_gap_cnt = (gap_cnt != LOSS_CYC) ? gap_cnt + 8'h01 : gap_cnt;
    end
    next_osc_loss  = loss_event || (osc_loss_o && !fail_clear_i);
    next_osc_dev   = dev_event || (osc_deviation_o && !fail_clear_i);
    next_emergency = (lock_prev && !pll_lock_i) || loss_event || (emergency_o && !fail_clear_i);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fb_cnt          <= 5'h00;
      gap_cnt         <= 8'h00;
      edge_seen       <= 1'b0;
      osc_prev        <= 1'b0;
      lock_prev       <= 1'b0;
      osc_loss_o      <= 1'b0;
      osc_deviation_o <= 1'b0;
      emergency_o     <= 1'b0;
    end else begin
      fb_cnt          <= next_fb_cnt;
      gap_cnt         <= next_gap_cnt;
      edge_seen       <= next_edge_seen;
      osc_prev        <= osc_ref_i;
      lock_prev       <= pll_lock_i;
      osc_loss_o      <= next_osc_loss;
      osc_deviation_o <= next_osc_dev;
      emergency_o     <= next_emergency;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_one_mode;
    $onehot(state);
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("sequencer state not one-hot");

  property p_run_clocks;
    // Gates still hold their reset value at the first edge after release
    state == PM_RUN && !$past(rst_i) |-> cpu_clk_en_o && sys_clk_en_o && periph_clk_en_o == $past(periph_enable_i);
  endproperty
  a_run_clocks: assert property (p_run_clocks) else $error("run gating wrong");

  property p_idle_clocks;
    state == PM_IDLE |-> !cpu_clk_en_o && sys_clk_en_o && periph_clk_en_o == $past(periph_enable_i);
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle gating wrong");

  property p_idle_entry;
    state == PM_RUN && idle_req_i && !sleep_req_i && !deep_sleep_req_i |=> state == PM_IDLE;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle request not taken");

  property p_idle_wake;
    state == PM_IDLE && (wdt_event_i || irq_enabled_i || nmi_fall) |=> state == PM_RUN ##0 cpu_clk_en_o;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");

  property p_sleep_clocks;
    state == PM_SLEEP |-> !cpu_clk_en_o &&
      periph_clk_en_o == ($past(periph_enable_i) & $past(periph_sleep_enable_i));
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks) else $error("sleep gating wrong");

  property p_sleep_wake;
    state == PM_SLEEP && wdt_event_i |=> state == PM_WAKE_CPU ##2 state == PM_RUN;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake sequence wrong");

  property p_shut_order;
    state == PM_RUN && (sleep_req_i || deep_sleep_req_i) |=>
      state == PM_SHUT_PERIPH && cpu_clk_en_o ##1 !cpu_clk_en_o && sys_clk_en_o;
  endproperty
  a_shut_order: assert property (p_shut_order) else $error("shutdown order wrong");

  property p_deep_hold;
    state == PM_DEEP && !ext_wake_i |=> state == PM_DEEP && !sys_clk_en_o && periph_clk_en_o == '0;
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("deep sleep left without external wake");

  property p_wake_order;
    state == PM_DEEP && ext_wake_i |=> sys_clk_en_o && !cpu_clk_en_o ##1 cpu_clk_en_o ##1 state == PM_WAKE_PERIPH;
  endproperty
  a_wake_order: assert property (p_wake_order) else $error("wake order wrong");

  property p_fb_dev;
    osc_rise && edge_seen && (fb_cnt < FB_LO || fb_cnt > FB_HI) |=> osc_deviation_o;
  endproperty
  a_fb_dev: assert property (p_fb_dev) else $error("feedback deviation missed");

  property p_kdiv16;
    output_divide_select_i == `KSEL_16 |=> div_factor_o == 5'h10;
  endproperty
  a_kdiv16: assert property (p_kdiv16) else $error("divider decode wrong");

  property p_tick_period;
    sys_tick_o && !emergency_o && $stable(output_divide_select_i) && k_sel == 5'h04 && vco_tick_i
      |=> !sys_tick_o ##1 !sys_tick_o ##1 !sys_tick_o;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("system tick period wrong");

  property p_lock_loss;
    !pll_lock_i && lock_prev |=> emergency_o;
  endproperty
  a_lock_loss: assert property (p_lock_loss) else $error("lock loss not flagged");

  c_idle_trip:  cover property (state == PM_IDLE ##[1:20] state == PM_RUN);
  c_sleep_trip: cover property (state == PM_SLEEP ##1 state == PM_WAKE_CPU);
  c_deep_trip:  cover property (state == PM_DEEP ##1 state == PM_WAKE_SYS);
  c_emergency:  cover property ($rose(emergency_o));

endmodule
`default_nettype wire

// file: test/osc_loop_model.sv
// Partner model: oscillator reference, loop output ticks and lock flag
`timescale 1ns/10ps
`default_nettype none

module osc_loop_model (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Bench controls: run, tick skew, lock hold
  input  wire logic run_i,
  input  wire logic skew_i,
  input  wire logic lock_keep_i,
  // Toward the controller
  output logic      osc_ref_o,
  output logic      vco_tick_o,
  output logic      pll_lock_o
);
  // ************************************************
  // Phase of the reference period
  // ************************************************
  int phase;

  // Steps on the falling edge, clear of the sampling edge
  always @(negedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= 0;
    end else if (run_i) begin
      phase <= (phase + 1) % 10;
    end
  end

  // Ten ticks per reference period unless skewed; stopped reference sits low
  assign osc_ref_o  = run_i & (phase < 5);
  assign vco_tick_o = run_i & (~skew_i | phase[0]);
  // Lock lost whenever the reference is gone
  assign pll_lock_o = run_i & lock_keep_i;
endmodule
`default_nettype wire

// file: test/power_mode_and_pll_clock_control_tb.sv
// Self-checking bench for the power mode sequencer and output divider
`timescale 1ns/10ps
`default_nettype none

module power_mode_and_pll_clock_control_tb;
  import pmc_pkg::*;
  localparam int NP = 8;
  logic          clk_sys_i, rst_i, idle_req, sleep_req, deep_req, fail_clear;
  logic          irq_en, wdt, nmi_n, ext_wake, run, skew, lock_keep, osc, vco, lock;
  logic          cpu_en, sys_en, tick, lvl, loss, dev, emer;
  logic [NP-1:0] en, sen, pirq, pclk;
  logic [2:0]    ksel;
  logic [4:0]    kfac;
  pm_state_type  mode;
  pm_state_type  q[$];
  int            n_errors, total_checks, seed, k, hi, nt;
  int            output_divide_select[8] = '{2, 16, 4, 5, 6, 8, 9, 10};

  // Clock at 40 MHz
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  power_mode_and_pll_clock_control uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .idle_req_i(idle_req), .sleep_req_i(sleep_req),
    .deep_sleep_req_i(deep_req), .periph_enable_i(en), .periph_sleep_enable_i(sen),
    .output_divide_select_i(ksel), .fail_clear_i(fail_clear), .irq_enabled_i(irq_en),
    .periph_irq_i(pirq), .wdt_event_i(wdt), .nmi_n_i(nmi_n), .ext_wake_i(ext_wake),
    .osc_ref_i(osc), .vco_tick_i(vco), .pll_lock_i(lock), .cpu_clk_en_o(cpu_en),
    .sys_clk_en_o(sys_en), .periph_clk_en_o(pclk), .power_mode_o(mode), .sys_tick_o(tick),
    .sys_clk_level_o(lvl), .div_factor_o(kfac), .osc_loss_o(loss), .osc_deviation_o(dev),
    .emergency_o(emer));

  osc_loop_model partner (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run), .skew_i(skew), .lock_keep_i(lock_keep),
    .osc_ref_o(osc), .vco_tick_o(vco), .pll_lock_o(lock));

  // ************************************************
  // Comparison, verdict and watchdog
  // ************************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run needs about 740 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    tally_and_finish();
  end

  // ************************************************
  // Reference model of the gates in each step
  // ************************************************
  function automatic logic [9:0] model_gates(input pm_state_type m);
    case (m)
      PM_RUN, PM_WAKE_PERIPH: model_gates = {2'b11, en};
      PM_IDLE: model_gates = {2'b01, en};
      PM_SHUT_PERIPH, PM_WAKE_CPU: model_gates = {2'b11, en & sen};
      PM_SHUT_CPU, PM_SLEEP, PM_WAKE_SYS: model_gates = {2'b01, en & sen};
      default: model_gates = 10'h000;
    endcase
  endfunction

  // Strobes back to rest; a one-edge pulse at most
  task automatic quiet();
    {idle_req, sleep_req, deep_req, irq_en, wdt, ext_wake} = 6'h00;
    pirq  = 8'h00;
    nmi_n = 1'b1;
  endtask

  // Steps through the expected states one edge at a time
  task automatic walk();
    foreach (q[i]) begin
      @(negedge clk_sys_i);
      if (i == 0) begin
        quiet();
      end
      chk("power_mode", 32'(mode), 32'(q[i]));
      chk("clock gates", 32'({cpu_en, sys_en, pclk}), 32'(model_gates(q[i])));
    end
    q.delete();
  endtask

  // Wake sources: enabled irq, watchdog, NMI fall, live peripheral, external
  task automatic wake(input int s);
    case (s)
      0: irq_en = 1'b1;
      1: wdt = 1'b1;
      2: nmi_n = 1'b0;
      3: pirq = 8'h01;
      default: ext_wake = 1'b1;
    endcase
  endtask

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    seed = 20712;
    n_errors = 0;
    total_checks = 0;
    quiet();
    {fail_clear, skew} = 2'b00;
    {rst_i, run, lock_keep} = 3'b111;
    ksel = 3'h7;
    en = 8'hFF;
    sen = 8'h00;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("reset mode", 32'(mode), 32'(PM_RUN));
    chk("reset gates", 32'({cpu_en, sys_en, pclk}), 32'h300);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    // Every divider code: factor, tick rate, duty
    for (int c = 0; c < 8; c++) begin
      ksel = c[2:0];
      repeat (20) @(negedge clk_sys_i);
      k = output_divide_select[c];
      nt = 0;
      hi = 0;
      repeat (4 * k) begin
        @(negedge clk_sys_i);
        nt += int'(tick);
        hi += int'(lvl);
      end
      chk("div_factor", 32'(kfac), 32'(k));
      chk("tick count", 32'(nt), 32'd4);
      chk("level count", 32'(hi), 32'(4 * (k / 2)));
    end
    // Rest of run uses factor ten, a setting software may choose
    ksel = 3'h7;
    // Random gating; peripheral 0 runs in Sleep, peripheral 1 does not
    for (int r = 0; r < 3; r++) begin
      en = 8'($random(seed)) | 8'h03;
      sen = (8'($random(seed)) | 8'h01) & 8'hFD;
      @(negedge clk_sys_i);
      for (int s = 0; s < 3; s++) begin
        idle_req = 1'b1;
        q = '{PM_IDLE};
        walk();
        wake(s);
        q = '{PM_RUN};
        walk();
      end
      for (int s = 1; s < 4; s++) begin
        sleep_req = 1'b1;
        q = '{PM_SHUT_PERIPH, PM_SHUT_CPU, PM_SLEEP};
        walk();
        // Stopped peripheral and stray request do not wake
        pirq = 8'h02;
        idle_req = 1'b1;
        q = '{PM_SLEEP, PM_SLEEP};
        walk();
        wake(s);
        q = '{PM_WAKE_CPU, PM_WAKE_PERIPH, PM_RUN};
        walk();
      end
      {deep_req, sleep_req} = 2'b11;
      q = '{PM_SHUT_PERIPH, PM_SHUT_CPU, PM_SHUT_SYS, PM_DEEP};
      walk();
      // Internal events must not restart; no system ticks meanwhile
      {wdt, irq_en, nmi_n} = 3'b110;
      pirq = 8'hFF;
      q = '{PM_DEEP, PM_DEEP};
      walk();
      nt = 0;
      repeat (12) begin
        @(negedge clk_sys_i);
        nt += int'(tick);
      end
      chk("deep ticks", 32'(nt), 32'd0);
      wake(4);
      q = '{PM_WAKE_SYS, PM_WAKE_CPU, PM_WAKE_PERIPH, PM_RUN};
      walk();
    end
    // Reset wakes Idle at once
    idle_req = 1'b1;
    q = '{PM_IDLE};
    walk();
    rst_i = 1'b1;
    #1;
    chk("reset wake", 32'(mode), 32'(PM_RUN));
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    // Reference loss, then clear
    run = 1'b0;
    repeat (25) @(negedge clk_sys_i);
    chk("loss flags", 32'({loss, emer}), 32'h3);
    run = 1'b1;
    fail_clear = 1'b1;
    repeat (30) @(negedge clk_sys_i);
    fail_clear = 1'b0;
    repeat (30) @(negedge clk_sys_i);
    chk("cleared flags", 32'({loss, dev, emer}), 32'h0);
    // Half the ticks per period: deviation
    skew = 1'b1;
    repeat (30) @(negedge clk_sys_i);
    chk("deviation", 32'({loss, dev}), 32'h1);
    skew = 1'b0;
    fail_clear = 1'b1;
    repeat (30) @(negedge clk_sys_i);
    fail_clear = 1'b0;
    repeat (25) @(negedge clk_sys_i);
    // Lock drop alone raises emergency on the next cycle
    lock_keep = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk("lock loss", 32'({loss, dev, emer}), 32'h1);
    lock_keep = 1'b1;
    tally_and_finish();
  end
endmodule
`default_nettype wire
